/* File: src/dgs_param_mem.sv */
// Parameter store: one write port, two registered read ports
`timescale 1ns/1ps
module dgs_param_mem
	import dgs_pkg::*;
(
	input wire logic ref_clk, // System clock
	input wire logic wr_en, // Write strobe
	input wire logic [dgs_pkg::MEM_AW-1:0] wr_addr, // Write entry
	input wire logic [dgs_pkg::MEM_DW-1:0] wr_data, // Write value
	input wire logic [dgs_pkg::MEM_AW-1:0] a_addr, // Bus read entry
	output logic [dgs_pkg::MEM_DW-1:0] a_data, // Bus read value
	input wire logic [dgs_pkg::MEM_AW-1:0] b_addr, // Sequencer read entry
	output logic [dgs_pkg::MEM_DW-1:0] b_data // Sequencer read value
);
	logic [MEM_DW-1:0] mem [MEM_DEPTH];

	// Contents are undefined until software loads them
	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		a_data <= mem[a_addr];
		b_data <= mem[b_addr];
	end
endmodule : dgs_param_mem

/* File: src/dgs_pkg.sv */
// Shared constants for the data group step sequencer
package dgs_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int MS_PER_S = 1000;
	localparam int TENTH_MS_PER_S = 10000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int CYC_PER_TENTH_MS = CLK_HZ / TENTH_MS_PER_S;

	// ------------------------------------------------------------
	// Parameter memory layout
	// ------------------------------------------------------------
	localparam int GROUPS = 8;
	localparam int ENTRIES_PER_GROUP = 8;
	localparam int MEM_DEPTH = GROUPS * ENTRIES_PER_GROUP;
	localparam int MEM_AW = 6;
	localparam int MEM_DW = 16;
	localparam int FIRST_ENTRY = 700;
	localparam logic [2:0] ENT_COND_TYPE = 3'h4;
	localparam logic [2:0] ENT_COND1_VAL = 3'h5;
	localparam logic [2:0] ENT_COND2_VAL = 3'h6;
	localparam logic [2:0] ENT_NEXT = 3'h7;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int AW = 12;
	localparam logic [11:0] ADDR_MEM_LAST = 12'h0FC;
	localparam logic [11:0] ADDR_FILT = 12'h100;
	localparam logic [11:0] ADDR_GEAR = 12'h104;
	localparam logic [11:0] ADDR_CTRL = 12'h108;
	localparam logic [11:0] ADDR_STAT = 12'h10C;
	localparam logic [11:0] ADDR_POS = 12'h110;
	localparam logic [11:0] ADDR_SCL_LO = 12'h114;
	localparam logic [11:0] ADDR_SCL_HI = 12'h118;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_START_LSB = 4;
	localparam int TYPE_C2_LSB = 4;
	localparam int TYPE_COMB_LSB = 8;
	localparam logic [10:0] FILT_RST = 11'h001;
	localparam logic [10:0] FILT_MAX = 11'd1000;
	localparam logic [29:0] GEAR_RST = 30'h0000_0001;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [3:0] CT_NONE = 4'h0;
	localparam logic [3:0] CT_DELAY = 4'h1;
	localparam logic [3:0] CT_EDGE = 4'h2;
	localparam logic [3:0] CT_LEVEL = 4'h3;
	localparam logic [15:0] V_RISE = 16'h0000;
	localparam logic [15:0] V_FALL = 16'h0001;
	localparam logic [15:0] V_BOTH = 16'h0002;
	localparam logic [15:0] V_HIGH = 16'h0003;
	localparam logic [15:0] V_LOW = 16'h0004;
	localparam logic [3:0] COMB_NONE = 4'h0;
	localparam logic [3:0] COMB_AND = 4'h1;
	localparam logic [3:0] COMB_OR = 4'h2;

	typedef enum logic [1:0]
	{
		DGS_IDLE = 2'b00,
		DGS_FETCH = 2'b01,
		DGS_EVAL = 2'b11
	} dgs_state_e;
endpackage : dgs_pkg

/* File: src/dgs_seq.sv */
// Data group step sequencer with APB register access
//
// Notes on behaviour
// [RULE_01] Condition value meaning follows its type: ignored, delay, edge or level.
// [RULE_02] Delay type waits value milliseconds, 0 to 65535, before satisfied.
// [RULE_03] Edge value 0 rising, 1 falling, 2 either; other values never satisfy.
// [RULE_04] Level value 3 high, 4 low; other values never satisfy.
// [RULE_05] Combination 0 uses condition one, 1 needs both, 2 needs either.
// [RULE_06] Next group index 0 to 7 becomes active once the step is met.
// [RULE_07] Each group owns eight consecutive parameter entries in order.
// [RULE_08] Step input filtered 0 to 1000 tenths of ms, default 1.
// [RULE_09] Gear numerator 1 to 1073741823, default 1, scales commanded position.
// [RULE_10] Type one: 0 immediate, 1 delay, 2 edge, 3 level.
// [RULE_11] Condition two decoded with the same encodings by its own type.
// [RULE_12] Delay and edge history restart whenever a new group is activated.
`timescale 1ns/1ps
module dgs_seq
	import dgs_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS
)
(
	input wire logic ref_clk, // 20 MHz clock
	input wire logic srst, // Synchronous reset, high
	input wire logic [dgs_pkg::AW-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic step_in, // Raw step change input
	output logic [2:0] active_group, // Group now active
	output logic group_adv, // Pulse on each step advance to the next group; none when a run starts
	output logic running, // Sequencer active
	output logic [63:0] pos_scaled // Position times gear numerator
);
	import dgs_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	localparam logic [16:0] MS_SAT = 17'h1_FFFF;
	localparam logic [22:0] TENTH_CYC = 23'(CYC_PER_TENTH_MS);
	localparam logic [14:0] MS_LAST = 15'(MS_CYCLES - 1);

	// One condition judged against its own type
	function automatic logic cond_eval(input logic [3:0] ctype,
		input logic [15:0] val, input logic [16:0] elapsed,
		input logic rise, input logic fall, input logic lvl);
		case (ctype)
			CT_NONE: cond_eval = 1'b1;
			CT_DELAY: cond_eval = elapsed >= {1'b0, val};
			CT_EDGE: cond_eval = (val == V_RISE) ? rise :
				(val == V_FALL) ? fall :
				(val == V_BOTH) ? (rise | fall) : 1'b0;
			CT_LEVEL: cond_eval = (val == V_HIGH) ? lvl :
				(val == V_LOW) ? !lvl : 1'b0;
			default: cond_eval = 1'b0;
		endcase
	endfunction : cond_eval

	dgs_state_e state_reg;
	logic [10:0] filt_time_reg;
	logic [29:0] gear_reg;
	logic run_reg, run_d_reg;
	logic [2:0] start_grp_reg;
	logic signed [31:0] pos_reg;
	logic [2:0] grp_reg;
	logic [2:0] fetch_step_reg;
	logic [15:0] ctype_reg, c1_val_reg, c2_val_reg;
	logic [2:0] next_reg;
	logic [14:0] ms_cyc_reg;
	logic [16:0] ms_elapsed_reg;
	logic filt_reg, filt_d_reg;
	logic [22:0] filt_cnt_reg;
	logic rise_seen_reg, fall_seen_reg;
	logic [MEM_DW-1:0] mem_a_data, mem_b_data;
	logic [MEM_AW-1:0] seq_addr;
	logic mem_hit, wr_acc, rd_first, c1, c2, adv, rise_now, fall_now;
	logic [3:0] ct1, ct2, comb;

	// ------------------------------------------------------------
	// APB slave: one wait state, write lands at the completing edge
	// ------------------------------------------------------------
	assign mem_hit = paddr <= ADDR_MEM_LAST;
	assign rd_first = psel && penable && !pready;
	assign wr_acc = psel && penable && pready && pwrite;

	// Handshake and read data; read is captured after memory latency
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (rd_first)
		begin
			pready <= 1'b1;
			pslverr <= !(mem_hit || paddr == ADDR_FILT ||
				paddr == ADDR_GEAR || paddr == ADDR_CTRL ||
				paddr == ADDR_STAT || paddr == ADDR_POS ||
				paddr == ADDR_SCL_LO || paddr == ADDR_SCL_HI);
			if (mem_hit)
				prdata <= {16'h0000, mem_a_data};
			else
				case (paddr)
					ADDR_FILT: prdata <= {21'h00_0000, filt_time_reg};
					ADDR_GEAR: prdata <= {2'b00, gear_reg};
					ADDR_CTRL: prdata <= {25'h000_0000, start_grp_reg,
						3'b000, run_reg};
					ADDR_STAT: prdata <= {24'h00_0000, c2, c1, filt_reg,
						running, 1'b0, grp_reg};
					ADDR_POS: prdata <= pos_reg;
					ADDR_SCL_LO: prdata <= pos_scaled[31:0];
					ADDR_SCL_HI: prdata <= pos_scaled[63:32];
					default: prdata <= 32'h0000_0000;
				endcase
		end
		else
			pready <= 1'b0;
	end

	// Software registers; filter values above 1000 are clamped to 1000, a zero gear loads 1
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			filt_time_reg <= FILT_RST; // RULE_08
			gear_reg <= GEAR_RST; // RULE_09
			run_reg <= 1'b0;
			start_grp_reg <= 3'h0;
			pos_reg <= 32'sh0000_0000;
		end
		else if (wr_acc)
			case (paddr)
				ADDR_FILT: filt_time_reg <= (pwdata[31:0] > 32'(FILT_MAX)) ?
					FILT_MAX : pwdata[10:0]; // RULE_08
				ADDR_GEAR: gear_reg <= (pwdata[29:0] == 30'h0000_0000) ?
					GEAR_RST : pwdata[29:0]; // RULE_09
				ADDR_CTRL:
				begin
					run_reg <= pwdata[CTRL_RUN_BIT];
					start_grp_reg <= pwdata[CTRL_START_LSB +: 3];
				end
				ADDR_POS: pos_reg <= pwdata;
				default: ;
			endcase
	end

	// Gear scaling; product is 62 bits, sign extended to 64
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			pos_scaled <= 64'h0000_0000_0000_0000;
		else
			pos_scaled <= 64'(pos_reg) *
				64'($signed({2'b00, gear_reg})); // RULE_09
	end

	// Group entries sit at group times eight plus entry offset
	assign seq_addr = {grp_reg, ENT_COND_TYPE + fetch_step_reg}; // RULE_07

	dgs_param_mem u_mem
	(
		.ref_clk(ref_clk),
		.wr_en(wr_acc && mem_hit),
		.wr_addr(paddr[7:2]),
		.wr_data(pwdata[15:0]),
		.a_addr(paddr[7:2]),
		.a_data(mem_a_data),
		.b_addr(seq_addr),
		.b_data(mem_b_data)
	);

	// ------------------------------------------------------------
	// Step input filter: change accepted after stable for the time
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			filt_reg <= 1'b0;
			filt_d_reg <= 1'b0;
			filt_cnt_reg <= 23'h00_0000;
		end
		else
		begin
			filt_d_reg <= filt_reg;
			if (step_in == filt_reg)
				filt_cnt_reg <= 23'h00_0000;
			else if (filt_time_reg == 11'h000 ||
				filt_cnt_reg + 23'h00_0001 >=
				23'(filt_time_reg * TENTH_CYC))
			begin
				filt_reg <= step_in; // RULE_08
				filt_cnt_reg <= 23'h00_0000;
			end
			else
				filt_cnt_reg <= filt_cnt_reg + 23'h00_0001;
		end
	end

	assign rise_now = filt_reg && !filt_d_reg;
	assign fall_now = !filt_reg && filt_d_reg;

	// ------------------------------------------------------------
	// Condition evaluation
	// ------------------------------------------------------------
	assign ct1 = ctype_reg[3:0];
	assign ct2 = ctype_reg[TYPE_C2_LSB +: 4];
	assign comb = ctype_reg[TYPE_COMB_LSB +: 4];
	assign c1 = cond_eval(ct1, c1_val_reg, ms_elapsed_reg,
		rise_now | rise_seen_reg, fall_now | fall_seen_reg,
		filt_reg); // RULE_01 RULE_02 RULE_03 RULE_04 RULE_10
	assign c2 = cond_eval(ct2, c2_val_reg, ms_elapsed_reg,
		rise_now | rise_seen_reg, fall_now | fall_seen_reg,
		filt_reg); // RULE_11

	// Immediate type bypasses condition two entirely
	always_comb
	begin
		adv = 1'b0;
		if (state_reg == DGS_EVAL)
		begin
			if (ct1 == CT_NONE)
				adv = 1'b1; // RULE_10
			else
				case (comb)
					COMB_AND: adv = c1 && c2; // RULE_05
					COMB_OR: adv = c1 || c2; // RULE_05
					default: adv = c1; // RULE_05
				endcase
		end
	end

	// Millisecond timebase and edge history, restarted per group
	always_ff @(posedge ref_clk)
	begin
		if (srst || state_reg != DGS_EVAL)
		begin
			ms_cyc_reg <= 15'h0000; // RULE_12
			ms_elapsed_reg <= 17'h0_0000; // RULE_12
			rise_seen_reg <= 1'b0; // RULE_12
			fall_seen_reg <= 1'b0; // RULE_12
		end
		else
		begin
			rise_seen_reg <= rise_seen_reg | rise_now;
			fall_seen_reg <= fall_seen_reg | fall_now;
			if (ms_cyc_reg == MS_LAST)
			begin
				ms_cyc_reg <= 15'h0000;
				if (ms_elapsed_reg != MS_SAT)
					ms_elapsed_reg <= ms_elapsed_reg + 17'h0_0001; // RULE_02
			end
			else
				ms_cyc_reg <= ms_cyc_reg + 15'h0001;
		end
	end

	// ------------------------------------------------------------
	// Sequencer: fetch four entries, then wait for the step
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			state_reg <= DGS_IDLE;
			run_d_reg <= 1'b0;
			grp_reg <= 3'h0;
			fetch_step_reg <= 3'h0;
			ctype_reg <= 16'h0000;
			c1_val_reg <= 16'h0000;
			c2_val_reg <= 16'h0000;
			next_reg <= 3'h0;
			group_adv <= 1'b0;
		end
		else
		begin
			run_d_reg <= run_reg;
			group_adv <= 1'b0;
			case (state_reg)
				DGS_IDLE:
					if (run_reg && !run_d_reg)
					begin
						grp_reg <= start_grp_reg;
						fetch_step_reg <= 3'h0;
						state_reg <= DGS_FETCH;
					end
				DGS_FETCH:
				begin
					case (fetch_step_reg)
						3'h1: ctype_reg <= mem_b_data;
						3'h2: c1_val_reg <= mem_b_data;
						3'h3: c2_val_reg <= mem_b_data;
						3'h4: next_reg <= mem_b_data[2:0]; // RULE_06
						default: ;
					endcase
					if (fetch_step_reg == 3'h4)
						state_reg <= DGS_EVAL;
					else
						fetch_step_reg <= fetch_step_reg + 3'h1;
				end
				DGS_EVAL:
					if (adv)
					begin
						grp_reg <= next_reg; // RULE_06
						group_adv <= 1'b1;
						fetch_step_reg <= 3'h0;
						state_reg <= DGS_FETCH;
					end
				default: state_reg <= DGS_IDLE;
			endcase
			if (!run_reg)
				state_reg <= DGS_IDLE;
		end
	end

	// Registered status outputs
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			active_group <= 3'h0;
			running <= 1'b0;
		end
		else
		begin
			active_group <= grp_reg;
			running <= state_reg != DGS_IDLE;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_AND_BOTH: assert property (@(posedge ref_clk) disable iff (srst) // RULE_05
		(adv && ct1 != CT_NONE && comb == COMB_AND) |-> (c1 && c2))
		else $error("and-combined advance without both conditions");
	AST_NEXT_LOAD: assert property (@(posedge ref_clk) disable iff (srst) // RULE_06
		(adv && run_reg) |=> (grp_reg == $past(next_reg)) ##1
		(active_group == $past(next_reg, 2)))
		else $error("next group not loaded");
	AST_DELAY: assert property (@(posedge ref_clk) disable iff (srst) // RULE_02
		(adv && ct1 == CT_DELAY && comb == COMB_NONE) |->
		(ms_elapsed_reg >= {1'b0, c1_val_reg}))
		else $error("delay advance too early");
	AST_RISE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_03
		(state_reg == DGS_EVAL && ct1 == CT_EDGE && c1_val_reg == V_RISE
		&& !rise_now && !rise_seen_reg) |-> !c1)
		else $error("rising condition without an edge");
	AST_LEVEL: assert property (@(posedge ref_clk) disable iff (srst) // RULE_04
		(ct1 == CT_LEVEL && c1_val_reg > V_LOW) |-> !c1)
		else $error("invalid level value satisfied");
	AST_FILT0: assert property (@(posedge ref_clk) disable iff (srst) // RULE_08
		(filt_time_reg == 11'h000 && $stable(filt_time_reg))
		|=> (filt_reg == $past(step_in)))
		else $error("zero filter does not pass input");
	AST_RESTART: assert property (@(posedge ref_clk) disable iff (srst) // RULE_12
		(state_reg == DGS_FETCH && fetch_step_reg == 3'h4) |=>
		(ms_elapsed_reg == 17'h0_0000 && !rise_seen_reg && !fall_seen_reg))
		else $error("history not cleared on activation");
	AST_IMMED: assert property (@(posedge ref_clk) disable iff (srst) // RULE_10
		(state_reg == DGS_EVAL && ct1 == CT_NONE && run_reg)
		|=> group_adv)
		else $error("immediate type did not advance");
	AST_ADDR: assert property (@(posedge ref_clk) disable iff (srst) // RULE_07
		(state_reg == DGS_FETCH) |-> (seq_addr[5:3] == grp_reg &&
		seq_addr[2:0] == 3'(4 + fetch_step_reg)))
		else $error("group entry address wrong");
endmodule : dgs_seq

/* File: tb/dgs_step_src.sv */
// Switch model that drives the raw step input during each case
`timescale 1ns/1ps
module dgs_step_src
#(
	parameter int SWITCH_AT = 50
)
(
	input wire logic ref_clk, // System clock
	input wire logic go, // High while a case runs
	input wire logic pre_lvl, // Level before the switch moves
	input wire logic post_lvl, // Level after the switch moves
	output logic step_in // Step input to the sequencer
);
	int cnt = 0;

	// ------------------------------------------------------------
	// Switch timing
	// ------------------------------------------------------------
	// Always driven, so the sequencer never sees an unknown level
	initial step_in = 1'b0;
	always @(posedge ref_clk)
	begin
		if (!go)
			cnt <= 0;
		else if (cnt < SWITCH_AT)
			cnt <= cnt + 1;
		step_in <= (cnt >= SWITCH_AT) ? post_lvl : pre_lvl;
	end
endmodule : dgs_step_src

/* File: tb/tb.sv */
// Self-checking bench for the data group step sequencer
`timescale 1ns/1ps
module tb;
	import dgs_pkg::*;
	typedef struct {
		logic [11:0] ty;
		logic [15:0] v1;
		logic [15:0] v2;
		logic pre;
		logic post;
		logic adv;
		logic [10:0] filt;
		int minw;
	} dgs_case_s;
	localparam int LIMIT = 80000;
	logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic go = 0, pre_lvl = 0, post_lvl = 0, step_in, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic err, group_adv, running;
	logic [2:0] active_group;
	logic [63:0] pos_scaled;
	int miscompares = 0, n_checks = 0, cyc = 0, seed = 46719;
	dgs_case_s cases [16] = '{
		'{12'h001, 2, 0, 0, 0, 1, 0, 38},
		'{12'h002, 0, 0, 0, 1, 1, 0, 50},
		'{12'h002, 1, 0, 1, 0, 1, 0, 50},
		'{12'h002, 2, 0, 0, 1, 1, 0, 50},
		'{12'h002, 2, 0, 1, 0, 1, 0, 50},
		'{12'h002, 5, 0, 0, 1, 0, 0, 0},
		'{12'h002, 0, 0, 1, 0, 0, 0, 0},
		'{12'h003, 3, 0, 0, 1, 1, 0, 50},
		'{12'h003, 4, 0, 1, 0, 1, 0, 50},
		'{12'h003, 7, 0, 1, 1, 0, 0, 0},
		'{12'h000, 0, 0, 0, 0, 1, 0, 0},
		'{12'h113, 3, 1, 1, 1, 1, 0, 20},
		'{12'h123, 3, 0, 1, 1, 0, 0, 0},
		'{12'h213, 3, 16'hFFFF, 1, 1, 1, 0, 0},
		'{12'h023, 3, 0, 1, 1, 1, 0, 0},
		'{12'h003, 3, 0, 0, 1, 1, 1, 50 + CYC_PER_TENTH_MS}
	};

	// ------------------------------------------------------------
	// Clock, timeout and instances
	// ------------------------------------------------------------
	always #25 ref_clk = ~ref_clk;
	// A hang is counted as a mismatch
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	dgs_seq #(.MS_CYCLES(20)) dut (.ref_clk(ref_clk), .srst(srst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .step_in(step_in),
		.active_group(active_group), .group_adv(group_adv),
		.running(running), .pos_scaled(pos_scaled));
	dgs_step_src src (.ref_clk(ref_clk), .go(go), .pre_lvl(pre_lvl),
		.post_lvl(post_lvl), .step_in(step_in));

	// ------------------------------------------------------------
	// Tasks and expectations
	// ------------------------------------------------------------
	task report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	task chk(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; entered and left just after a rising edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		// Only the bench timeout ends a wait that never completes
		do
		begin
			@(posedge ref_clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge ref_clk);
	endtask : apb

	function automatic logic [63:0] exp_scaled(logic [31:0] p,
		logic [29:0] g);
		longint ps, gg;
		ps = longint'($signed(p));
		gg = longint'(g);
		return 64'(ps * gg);
	endfunction : exp_scaled

	// Program group 0, start there and watch the first advance
	task run_case(input dgs_case_s c);
		logic [2:0] nx;
		int w;
		nx = 3'(1 + ($unsigned($random(seed)) % 7));
		apb(1, ADDR_CTRL, 0);
		pre_lvl <= c.pre;
		post_lvl <= c.post;
		apb(1, ADDR_FILT, 32'(c.filt));
		apb(1, 12'h010, 32'(c.ty));
		apb(1, 12'h014, 32'(c.v1));
		apb(1, 12'h018, 32'(c.v2));
		apb(1, 12'h01C, 32'(nx));
		apb(1, ADDR_CTRL, 1);
		go <= 1;
		w = 0;
		do
		begin
			@(posedge ref_clk);
			w++;
		end
		while (group_adv !== 1'b1 && w < 3000);
		chk("advance", 64'(c.adv), 64'(group_adv));
		chk("running", 1, 64'(running));
		if (c.adv)
		begin
			// Group output follows the advance pulse by one cycle
			@(posedge ref_clk);
			chk("next group", 64'(nx), 64'(active_group));
			chk("wait long enough", 1, 64'(w >= c.minw));
		end
		go <= 0;
		@(posedge ref_clk);
	endtask : run_case

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [31:0] p;
		logic [29:0] g;
		repeat (16) @(posedge ref_clk);
		srst <= 0;
		@(posedge ref_clk);
		apb(0, ADDR_FILT, 0);
		chk("filter reset", 1, 64'(rd));
		apb(0, ADDR_GEAR, 0);
		chk("gear reset", 1, 64'(rd));
		apb(0, 12'h200, 0);
		chk("unmapped error", 1, 64'(err));
		apb(1, ADDR_FILT, 1001);
		apb(0, ADDR_FILT, 0);
		chk("filter clamp", 1000, 64'(rd));
		apb(1, 12'h05C, 5);
		apb(0, 12'h05C, 0);
		chk("group 2 next", 5, 64'(rd));
		apb(1, ADDR_GEAR, 0);
		apb(0, ADDR_GEAR, 0);
		chk("gear zero", 1, 64'(rd));
		// Random gear and position against the scaled product
		repeat (4)
		begin
			p = $random(seed);
			g = 30'($random(seed)) | 30'h1;
			apb(1, ADDR_GEAR, 32'(g));
			apb(1, ADDR_POS, p);
			repeat (4) @(posedge ref_clk);
			chk("scaled", exp_scaled(p, g), pos_scaled);
			apb(0, ADDR_SCL_LO, 0);
			chk("scaled low", 64'(exp_scaled(p, g) & 64'hFFFF_FFFF),
				64'(rd));
			apb(0, ADDR_SCL_HI, 0);
			chk("scaled high", exp_scaled(p, g) >> 32, 64'(rd));
			apb(0, ADDR_POS, 0);
			chk("position", 64'(p), 64'(rd));
		end
		foreach (cases[i])
			run_case(cases[i]);
		report_and_stop();
	end
endmodule : tb
